// *** rtl/psp_pwm_cfg.sv ***
// Notes on behaviour
// - clear enable bit: pin follows port data
// - set enable bit: pin follows generator output
// - two-bit sync select per module
// - codes 00/01: A leading / trailing edge
// - codes 10/11: B leading / trailing edge
// - lock set: compare/output config copies frozen
// - mode bit: 0 one ramp, 1 center
// - B polarity: 0 active low, 1 high
// - A polarity: 0 active low, 1 high
// - divider field: 1, 4, 32, 256
// - clock select: 1 fast, 0 slow
`timescale 1ns/1ns
`default_nettype none
module psp_pwm_cfg
	import psp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pll_tick,
	input  wire logic        io_tick,
	input  wire logic [2:0]  fault_a,
	input  wire logic [2:0]  fault_b,
	input  wire logic [4:0]  port_out,
	output logic      [4:0]  pin_out,
	output logic      [2:0]  adc_sync,
	output logic      [7:0]  output_config
);
	typedef struct packed {
		logic [7:0]             pin_en;
		logic [7:0]             sync_sel;
		logic [7:0]             cnf;
		logic [7:0]             ctl;
		logic [7:0]             output_config_reg;
		logic [7:0]             poc_act;
		logic [2:0][3:0][7:0]   cmp;
		logic [2:0][3:0][7:0]   cmp_act;
		logic [31:0]            prdata;
		logic [4:0]             pin;
		logic [2:0]             sync;
	} psp_cfg_s;

	psp_cfg_s st_r;
	psp_cfg_s st_nxt;

	logic              src_tick;
	logic              gen_tick;
	logic [5:0]        raw;
	logic [2:0][3:0]   ev;
	logic [2:0][7:0]   cnt;
	logic              acc;
	logic              setup;

	function automatic logic is_cmp(input logic [11:0] a);
		is_cmp = (a >= PSP_OFF_CMP_BASE) && (a < PSP_OFF_CMP_END);
	endfunction

	function automatic logic [1:0] cmp_mod(input logic [11:0] a);
		logic [11:0] d;
		d       = a - PSP_OFF_CMP_BASE;
		cmp_mod = d[PSP_CMP_MOD_LSB +: 2];
	endfunction

	function automatic logic [1:0] cmp_idx(input logic [11:0] a);
		cmp_idx = a[PSP_CMP_IDX_LSB +: 2];
	endfunction

	function automatic logic is_known(input logic [11:0] a);
		logic k;
		k = 1'b0;
		if (a[1:0] == 2'h0) begin
			case (a)
				PSP_OFF_PIN_EN, PSP_OFF_SYNC, PSP_OFF_CNF, PSP_OFF_CTL, PSP_OFF_POC,
				PSP_OFF_STATUS, PSP_OFF_CNT0, PSP_OFF_CNT1, PSP_OFF_CNT2: k = 1'b1;
				default: k = is_cmp(a);
			endcase
		end
		is_known = k;
	endfunction

	// pick the event selected by a two-bit sync field
	function automatic logic sync_pick(input logic [1:0] sel, input logic [3:0] e);
		logic r;
		case (psp_sync_e'(sel))
			PSP_SYNC_LEAD_A:  r = e[PSP_EV_LEAD_A];
			PSP_SYNC_TRAIL_A: r = e[PSP_EV_TRAIL_A];
			PSP_SYNC_LEAD_B:  r = e[PSP_EV_LEAD_B];
			PSP_SYNC_TRAIL_B: r = e[PSP_EV_TRAIL_B];
			default:          r = 1'b0;
		endcase
		sync_pick = r;
	endfunction

	assign setup = psel && !penable;
	assign acc   = psel && penable;

	// clock source choice
	assign src_tick = st_r.ctl[PSP_CTL_CLKSEL_BIT] ? pll_tick : io_tick;

	psp_prescaler u_pre (
		.pclk     (pclk),
		.presetn  (presetn),
		.src_tick (src_tick),
		.div_sel  (st_r.ctl[PSP_CTL_PRE_LSB +: 2]),
		.tick     (gen_tick)
	);

	genvar m;
	generate
		for (m = 0; m < PSP_NUM_MOD; m++) begin : g_mod
			psp_wavegen u_gen (
				.pclk    (pclk),
				.presetn (presetn),
				.tick    (gen_tick),
				.center  (st_r.cnf[PSP_CNF_MODE_BIT]),
				.cmp_sa  (st_r.cmp_act[m][PSP_CMP_SA]),
				.cmp_ra  (st_r.cmp_act[m][PSP_CMP_RA]),
				.cmp_sb  (st_r.cmp_act[m][PSP_CMP_SB]),
				.cmp_rb  (st_r.cmp_act[m][PSP_CMP_RB]),
				.fault_a (fault_a[m]),
				.fault_b (fault_b[m]),
				.out_a   (raw[2*m]),
				.out_b   (raw[2*m+1]),
				.events  (ev[m]),
				.count   (cnt[m])
			);
		end
	endgenerate

	always_comb begin
		logic [31:0] rd;
		logic [1:0]  mi;
		logic [1:0]  ki;
		logic        pol;
		rd     = '0;
		mi     = cmp_mod(paddr);
		ki     = cmp_idx(paddr);
		pol    = 1'b0;
		st_nxt = st_r;

		// register writes, taken in the access phase
		if (acc && pwrite) begin
			case (paddr)
				PSP_OFF_PIN_EN: st_nxt.pin_en   = pwdata[7:0] & PSP_PIN_EN_MASK;
				PSP_OFF_SYNC:   st_nxt.sync_sel = pwdata[7:0] & PSP_SYNC_MASK;
				PSP_OFF_CNF:    st_nxt.cnf      = pwdata[7:0] & PSP_CNF_MASK;
				PSP_OFF_CTL:    st_nxt.ctl      = pwdata[7:0] & PSP_CTL_MASK;
				PSP_OFF_POC:    st_nxt.output_config_reg      = pwdata[7:0];
				default: begin
					if (is_cmp(paddr) && paddr[1:0] == 2'h0) begin
						st_nxt.cmp[mi][ki] = pwdata[7:0];
					end
				end
			endcase
		end

		// working copies follow software only while unlocked
		if (!st_r.cnf[PSP_CNF_LOCK_BIT]) begin
			st_nxt.cmp_act = st_r.cmp;
			st_nxt.poc_act = st_r.output_config_reg;
		end

		// read data captured in the setup phase
		case (paddr)
			PSP_OFF_PIN_EN: rd[7:0] = st_r.pin_en;
			PSP_OFF_SYNC:   rd[7:0] = st_r.sync_sel;
			PSP_OFF_CNF:    rd[7:0] = st_r.cnf;
			PSP_OFF_CTL:    rd[7:0] = st_r.ctl;
			PSP_OFF_POC:    rd[7:0] = st_r.output_config_reg;
			PSP_OFF_STATUS: rd[5:0] = raw;
			PSP_OFF_CNT0:   rd[7:0] = cnt[0];
			PSP_OFF_CNT1:   rd[7:0] = cnt[1];
			PSP_OFF_CNT2:   rd[7:0] = cnt[2];
			default: begin
				if (is_cmp(paddr) && paddr[1:0] == 2'h0) begin
					rd[7:0] = st_r.cmp[mi][ki];
				end
			end
		endcase
		if (setup && !pwrite) begin
			st_nxt.prdata = rd;
		end

		// pin routing with polarity
		for (int i = 0; i < PSP_NUM_PIN; i++) begin
			pol = (i % 2 == 0) ? st_r.cnf[PSP_CNF_POLA_BIT] : st_r.cnf[PSP_CNF_POLB_BIT];
			if (st_r.pin_en[i]) begin
				st_nxt.pin[i] = ~(raw[i] ^ pol);
			end else begin
				st_nxt.pin[i] = port_out[i];
			end
		end

		// adc sync pulses, one per selected event
		for (int j = 0; j < PSP_NUM_MOD; j++) begin
			st_nxt.sync[j] = sync_pick(st_r.sync_sel[j*PSP_SYNC_FW +: PSP_SYNC_FW], ev[j]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready        = acc;
	assign pslverr       = acc && !is_known(paddr);
	assign prdata        = st_r.prdata;
	assign pin_out       = st_r.pin;
	assign adc_sync      = st_r.sync;
	assign output_config = st_r.poc_act;
endmodule
`default_nettype wire

// *** rtl/psp_pkg.sv ***
package psp_pkg;
	localparam int unsigned PSP_NUM_MOD = 3;
	localparam int unsigned PSP_NUM_PIN = 5;
	localparam int unsigned PSP_NUM_CMP = 4;
	localparam int unsigned PSP_AW      = 12;
	localparam int unsigned PSP_DW      = 32;
	localparam int unsigned PSP_RW      = 8;

	// byte addresses
	localparam logic [11:0] PSP_OFF_PIN_EN   = 12'h000;
	localparam logic [11:0] PSP_OFF_SYNC     = 12'h004;
	localparam logic [11:0] PSP_OFF_CNF      = 12'h008;
	localparam logic [11:0] PSP_OFF_CTL      = 12'h00C;
	localparam logic [11:0] PSP_OFF_POC      = 12'h010;
	localparam logic [11:0] PSP_OFF_STATUS   = 12'h014;
	localparam logic [11:0] PSP_OFF_CNT0     = 12'h018;
	localparam logic [11:0] PSP_OFF_CNT1     = 12'h01C;
	localparam logic [11:0] PSP_OFF_CNT2     = 12'h020;
	localparam logic [11:0] PSP_OFF_CMP_BASE = 12'h040;
	localparam logic [11:0] PSP_OFF_CMP_END  = 12'h070;
	localparam int unsigned PSP_CMP_MOD_LSB  = 4;
	localparam int unsigned PSP_CMP_IDX_LSB  = 2;

	// write masks and reset values
	localparam logic [7:0] PSP_PIN_EN_MASK = 8'h1F;
	localparam logic [7:0] PSP_SYNC_MASK   = 8'hFF;
	localparam logic [7:0] PSP_CNF_MASK    = 8'h3C;
	localparam logic [7:0] PSP_CTL_MASK    = 8'hFF;
	localparam logic [7:0] PSP_RST_VAL     = 8'h00;

	// field positions
	localparam int unsigned PSP_CNF_LOCK_BIT   = 5;
	localparam int unsigned PSP_CNF_MODE_BIT   = 4;
	localparam int unsigned PSP_CNF_POLB_BIT   = 3;
	localparam int unsigned PSP_CNF_POLA_BIT   = 2;
	localparam int unsigned PSP_CTL_PRE_LSB    = 6;
	localparam int unsigned PSP_CTL_CLKSEL_BIT = 5;
	localparam int unsigned PSP_SYNC_FW        = 2;

	// compare slots within a module
	localparam logic [1:0] PSP_CMP_SA = 2'h0;
	localparam logic [1:0] PSP_CMP_RA = 2'h1;
	localparam logic [1:0] PSP_CMP_SB = 2'h2;
	localparam logic [1:0] PSP_CMP_RB = 2'h3;

	// divider terminal counts for /1, /4, /32, /256
	localparam logic [7:0] PSP_DIV1_LIM   = 8'h00;
	localparam logic [7:0] PSP_DIV4_LIM   = 8'h03;
	localparam logic [7:0] PSP_DIV32_LIM  = 8'h1F;
	localparam logic [7:0] PSP_DIV256_LIM = 8'hFF;

	localparam logic [7:0] PSP_CNT_TOP  = 8'hFF;
	localparam logic [7:0] PSP_CNT_ZERO = 8'h00;
	localparam logic [7:0] PSP_CNT_ONE  = 8'h01;

	typedef enum logic [1:0] {
		PSP_SYNC_LEAD_A  = 2'h0,
		PSP_SYNC_TRAIL_A = 2'h1,
		PSP_SYNC_LEAD_B  = 2'h2,
		PSP_SYNC_TRAIL_B = 2'h3
	} psp_sync_e;

	typedef enum logic [1:0] {
		PSP_DIV_1   = 2'h0,
		PSP_DIV_4   = 2'h1,
		PSP_DIV_32  = 2'h2,
		PSP_DIV_256 = 2'h3
	} psp_div_e;

	typedef enum logic {
		PSP_DIR_UP   = 1'b0,
		PSP_DIR_DOWN = 1'b1
	} psp_dir_e;

	// event bit positions in a generator's event vector
	localparam int unsigned PSP_EV_LEAD_A  = 0;
	localparam int unsigned PSP_EV_TRAIL_A = 1;
	localparam int unsigned PSP_EV_LEAD_B  = 2;
	localparam int unsigned PSP_EV_TRAIL_B = 3;
endpackage

// *** rtl/psp_prescaler.sv ***
`timescale 1ns/1ns
`default_nettype none
module psp_prescaler
	import psp_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       src_tick,
	input  wire logic [1:0] div_sel,
	output logic            tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} psp_pre_s;

	psp_pre_s st_r;
	psp_pre_s st_nxt;
	logic [7:0] lim;

	always_comb begin
		case (psp_div_e'(div_sel))
			PSP_DIV_1:   lim = PSP_DIV1_LIM;
			PSP_DIV_4:   lim = PSP_DIV4_LIM;
			PSP_DIV_32:  lim = PSP_DIV32_LIM;
			PSP_DIV_256: lim = PSP_DIV256_LIM;
			default:     lim = PSP_DIV1_LIM;
		endcase
	end

	// count source ticks, pulse on terminal count
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (src_tick) begin
			if (st_r.cnt >= lim) begin
				st_nxt.cnt  = PSP_CNT_ZERO;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + PSP_CNT_ONE;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule
`default_nettype wire

// *** rtl/psp_wavegen.sv ***
`timescale 1ns/1ns
`default_nettype none
module psp_wavegen
	import psp_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       tick,
	input  wire logic       center,
	input  wire logic [7:0] cmp_sa,
	input  wire logic [7:0] cmp_ra,
	input  wire logic [7:0] cmp_sb,
	input  wire logic [7:0] cmp_rb,
	input  wire logic       fault_a,
	input  wire logic       fault_b,
	output logic            out_a,
	output logic            out_b,
	output logic [3:0]      events,
	output logic [7:0]      count
);
	typedef struct packed {
		logic [7:0] cnt;
		psp_dir_e   dir;
		logic       out_a;
		logic       out_b;
		logic [3:0] ev;
	} psp_gen_s;

	psp_gen_s st_r;
	psp_gen_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.ev = '0;
		if (tick) begin
			// one ramp wraps, center aligned counts up then down
			if (!center) begin
				st_nxt.dir = PSP_DIR_UP;
				st_nxt.cnt = (st_r.cnt == PSP_CNT_TOP) ? PSP_CNT_ZERO : st_r.cnt + PSP_CNT_ONE;
			end else begin
				case (st_r.dir)
					PSP_DIR_UP: begin
						if (st_r.cnt == PSP_CNT_TOP) begin
							st_nxt.dir = PSP_DIR_DOWN;
							st_nxt.cnt = st_r.cnt - PSP_CNT_ONE;
						end else begin
							st_nxt.cnt = st_r.cnt + PSP_CNT_ONE;
						end
					end
					PSP_DIR_DOWN: begin
						if (st_r.cnt == PSP_CNT_ZERO) begin
							st_nxt.dir = PSP_DIR_UP;
							st_nxt.cnt = st_r.cnt + PSP_CNT_ONE;
						end else begin
							st_nxt.cnt = st_r.cnt - PSP_CNT_ONE;
						end
					end
					default: st_nxt.dir = PSP_DIR_UP;
				endcase
			end
			if (st_r.cnt == cmp_sa && !st_r.out_a) begin
				st_nxt.out_a              = 1'b1;
				st_nxt.ev[PSP_EV_LEAD_A]  = 1'b1;
			end
			if (st_r.cnt == cmp_ra && st_r.out_a) begin
				st_nxt.out_a              = 1'b0;
				st_nxt.ev[PSP_EV_TRAIL_A] = 1'b1;
			end
			if (st_r.cnt == cmp_sb && !st_r.out_b) begin
				st_nxt.out_b              = 1'b1;
				st_nxt.ev[PSP_EV_LEAD_B]  = 1'b1;
			end
			if (st_r.cnt == cmp_rb && st_r.out_b) begin
				st_nxt.out_b              = 1'b0;
				st_nxt.ev[PSP_EV_TRAIL_B] = 1'b1;
			end
		end
		// fault ends the active part at once, counted as a trailing edge
		if (fault_a && st_r.out_a) begin
			st_nxt.out_a              = 1'b0;
			st_nxt.ev[PSP_EV_LEAD_A]  = 1'b0;
			st_nxt.ev[PSP_EV_TRAIL_A] = 1'b1;
		end
		if (fault_b && st_r.out_b) begin
			st_nxt.out_b              = 1'b0;
			st_nxt.ev[PSP_EV_LEAD_B]  = 1'b0;
			st_nxt.ev[PSP_EV_TRAIL_B] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_a  = st_r.out_a;
	assign out_b  = st_r.out_b;
	assign events = st_r.ev;
	assign count  = st_r.cnt;
endmodule
`default_nettype wire

// *** verif/psp_pwm_cfg_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module psp_pwm_cfg_asserts
	import psp_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [4:0]  port_out,
	input wire logic [4:0]  pin_out,
	input wire logic [2:0]  adc_sync,
	input wire logic [7:0]  output_config
);
	logic [4:0] en_r;
	logic       lock_r;
	logic [7:0] poc_r;
	wire        acc = psel & penable;
	wire        wr = acc & pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of the fields the pin and copy logic depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= 5'h0;
			lock_r <= 1'b0;
			poc_r <= 8'h00;
		end else if (wr) begin
			if (paddr == PSP_OFF_PIN_EN)
				en_r <= pwdata[4:0];
			if (paddr == PSP_OFF_CNF)
				lock_r <= pwdata[PSP_CNF_LOCK_BIT];
			if (paddr == PSP_OFF_POC)
				poc_r <= pwdata[7:0];
		end
	end
	chk_ready_access: assert property (acc |-> pready) else $error("no ready");
	chk_ready_idle: assert property (!psel |-> !pready) else $error("stray ready");
	chk_err_unaligned: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("no error");
	chk_err_hole: assert property (acc && paddr inside {[12'h024:12'h03C]} |-> pslverr) else $error("no error");
	chk_pin_port: assert property ($past(presetn) |-> (~$past(en_r) & (pin_out ^ $past(port_out))) == 5'h0)
		else $error("pin not port");
	chk_lock_hold: assert property ($past(lock_r) |-> $stable(output_config))
		else $error("copy moved");
	chk_copy_follow: assert property ($past(presetn) && !$past(lock_r) |-> output_config == $past(poc_r))
		else $error("copy stale");
	chk_sync_single: assert property (adc_sync != 3'h0 |=> (adc_sync & $past(adc_sync)) == 3'h0)
		else $error("long pulse");
	cover property (wr && paddr == PSP_OFF_CNF);
	cover property (acc && pslverr);
	cover property (adc_sync[0]);
endmodule
bind psp_pwm_cfg psp_pwm_cfg_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .port_out(port_out),
	.pin_out(pin_out), .adc_sync(adc_sync), .output_config(output_config)
);
`default_nettype wire

// *** verif/psp_stage_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module psp_stage_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       go,
	input  wire logic       use_pll,
	input  wire logic [9:0] n_req,
	input  wire logic [1:0] gap,
	output logic            busy,
	output logic            io_tick,
	output logic            pll_tick,
	output logic [4:0]      port_out
);
	logic [9:0] left_r;
	logic [1:0] wait_r;
	assign busy = (left_r != 10'h0);
	// tick bursts, gap idle cycles between ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= 10'h0;
			wait_r <= 2'h0;
			io_tick <= 1'b0;
			pll_tick <= 1'b0;
			port_out <= 5'h0;
		end else begin
			port_out <= port_out + 5'h0B;
			io_tick <= 1'b0;
			pll_tick <= 1'b0;
			if (go) begin
				left_r <= n_req;
				wait_r <= 2'h0;
			end else if (busy && wait_r != 2'h0) begin
				wait_r <= wait_r - 2'h1;
			end else if (busy) begin
				io_tick <= !use_pll;
				pll_tick <= use_pll;
				left_r <= left_r - 10'h1;
				wait_r <= gap;
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/power_stage_pwm_config_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module power_stage_pwm_config_bench
	import psp_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, perr, io_tick, pll_tick, busy;
	logic        go = 1'b0;
	logic        use_pll = 1'b0;
	logic [9:0]  n_req = 10'h0;
	logic [1:0]  gap = 2'h0;
	logic [4:0]  port_out, pin_out, e, p;
	logic [2:0]  adc_sync;
	logic [2:0]  fa = 3'h0;
	logic [2:0]  fb = 3'h0;
	logic [7:0]  output_config, v, c;
	int          mismatches = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n;
	int          acnt[3] = '{0, 0, 0};
	int          snap[3];
	int          dv[4] = '{1, 4, 32, 256};
	logic [11:0] al[7] = '{PSP_OFF_PIN_EN, PSP_OFF_SYNC, PSP_OFF_CNF, PSP_OFF_CTL, PSP_OFF_POC, 12'h040, 12'h06C};
	logic [7:0]  ml[7] = '{8'h1F, 8'hFF, 8'h3C, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	psp_pwm_cfg dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pll_tick(pll_tick), .io_tick(io_tick), .fault_a(fa), .fault_b(fb), .port_out(port_out),
		.pin_out(pin_out), .adc_sync(adc_sync), .output_config(output_config)
	);
	psp_stage_model far (
		.pclk(pclk), .presetn(presetn), .go(go), .use_pll(use_pll), .n_req(n_req), .gap(gap),
		.busy(busy), .io_tick(io_tick), .pll_tick(pll_tick), .port_out(port_out)
	);
	initial forever #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		for (int m = 0; m < 3; m++)
			acnt[m] += adc_sync[m];
		if (cyc == 60000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk(rd, x);
	endtask
	task automatic burst(input logic s, input int k, input logic [1:0] g);
		@(posedge pclk);
		use_pll <= s;
		n_req <= k[9:0];
		gap <= g;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		while (busy !== 1'b0)
			@(posedge pclk);
		repeat (4)
			@(posedge pclk);
	endtask
	initial begin
		void'($urandom(32'haf03));
		repeat (6)
			@(posedge pclk);
		presetn <= 1'b1;
		foreach (al[i])
			rdc(al[i], 32'h0);
		apb(1'b1, 12'h024, 8'hFF);
		chk(perr, 32'h1);
		apb(1'b0, 12'h006, 8'h00);
		chk(perr, 32'h1);
		apb(1'b1, PSP_OFF_CNT0, 8'hA5);
		rdc(PSP_OFF_CNT0, 32'h0);
		// pins before any tick: generator outputs still inactive
		for (int k = 0; k < 4; k++) begin
			e = 5'($urandom);
			apb(1'b1, PSP_OFF_CNF, 8'(k << 2));
			apb(1'b1, PSP_OFF_PIN_EN, {3'h0, e});
			repeat (3)
				@(negedge pclk);
			p = port_out;
			@(negedge pclk);
			v = {3'h0, k[0], k[1], k[0], k[1], k[0]};
			chk(pin_out, (e & ~v[4:0]) | (~e & p));
		end
		apb(1'b1, PSP_OFF_CNF, 8'h20);
		v = 8'($urandom) | 8'h01;
		apb(1'b1, PSP_OFF_POC, v);
		repeat (2)
			@(negedge pclk);
		chk(output_config, 32'h0);
		apb(1'b1, PSP_OFF_CNF, 8'h00);
		repeat (2)
			@(negedge pclk);
		chk(output_config, v);
		for (int i = 0; i < 16; i++) begin
			n = (i[3:2] == 2'h3) ? 512 : 320;
			apb(1'b1, PSP_OFF_CTL, {i[3:2], i[1], 5'h0});
			apb(1'b0, PSP_OFF_CNT0, 8'h00);
			c = rd[7:0];
			burst(i[0], n, 2'($urandom));
			apb(1'b0, PSP_OFF_CNT0, 8'h00);
			chk(8'(rd[7:0] - c), (i[1] == i[0]) ? 8'(n / dv[i[3:2]]) : 8'h0);
		end
		for (int m = 0; m < 12; m++)
			apb(1'b1, PSP_OFF_CMP_BASE + 12'(16 * (m / 4) + 4 * (m % 4)), 8'(8'h10 << (m % 4)));
		apb(1'b1, PSP_OFF_CTL, 8'h20);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, PSP_OFF_SYNC, 8'(s * 8'h15));
			burst(1'b1, 256, 2'h0);
			snap = acnt;
			burst(1'b1, 512, 2'h0);
			for (int m = 0; m < 3; m++)
				chk(acnt[m] - snap[m], 32'h2);
		end
		// second reset, then center mode count and fault-ended pulses
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2)
			@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, PSP_OFF_CTL, 8'h20);
		apb(1'b1, PSP_OFF_CNF, 8'h10);
		for (int m = 0; m < 3; m++)
			apb(1'b1, PSP_OFF_CMP_BASE + 12'(16 * m), 8'h05);
		n = 256 + int'($urandom % 200);
		burst(1'b1, n, 2'h0);
		rdc(PSP_OFF_CNT0, 32'(510 - n));
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, PSP_OFF_SYNC, f ? 8'h3F : 8'h15);
			snap = acnt;
			@(posedge pclk);
			fa <= f ? 3'h0 : 3'h7;
			fb <= f ? 3'h7 : 3'h0;
			@(posedge pclk);
			fa <= 3'h0;
			fb <= 3'h0;
			repeat (4)
				@(posedge pclk);
			for (int m = 0; m < 3; m++)
				chk(acnt[m] - snap[m], 32'h1);
		end
		foreach (al[i]) begin
			v = 8'($urandom);
			apb(1'b1, al[i], v);
			rdc(al[i], v & ml[i]);
		end
		test_done();
	end
endmodule
`default_nettype wire
